// ===== logic/tlpi_ctrl.sv
// tlpi_ctrl: two-level priority interrupt controller, top module
// assumes: core pulses instr_boundary once per instruction cycle and pulses
// return_from_handler_instr when it executes the return instruction; pins are async
//
// The register offsets and the plain strobed port were chosen for this implementation.
`timescale 1ns/1ps
module tlpi_ctrl
	import tlpi_pkg::*;
#(
	parameter int unsigned NSRC = 8
) (
	input  wire logic                 ref_clk,
	input  wire logic                 rst_n,
	input  wire logic [ADDR_W-1:0]    reg_addr,
	input  wire logic [DATA_W-1:0]    reg_wdata,
	input  wire logic                 reg_wr,
	input  wire logic                 reg_rd,
	output logic      [DATA_W-1:0]    reg_rdata,
	input  wire logic                 line_zero_pin,
	input  wire logic [PORT_PINS-1:0] upper_port_change_pins,
	input  wire logic [NSRC-1:0]      periph_event,
	input  wire logic                 instr_boundary,
	input  wire logic                 return_from_handler_instr,
	output logic                      vector_take,
	output logic                      push_return,
	output logic      [VEC_W-1:0]     vector_addr,
	output logic                      handler_active_hi,
	output logic                      handler_active_lo
);

	// elaboration check: flags must fit one register, core sources must exist
	if (NSRC > DATA_W || NSRC < CORE_SRC_N) begin : g_bad_nsrc
		$error("tlpi_ctrl: NSRC out of range");
	end

	// register state
	logic                 global_irq_enable_ff;
	logic                 peripheral_irq_enable_ff;
	logic                 priority_feature_enable_ff;
	logic                 edge_rise_ff;
	logic [NSRC-1:0]      enable_ff;
	logic [NSRC-1:0]      prio_ff;
	logic [DATA_W-1:0]    rdata_ff;
	tlpi_level_e          level_ff;
	tlpi_level_e          nxt_level;
	logic                 nxt_gie;
	logic                 nxt_peripheral_irq_enable;

	// pin synchronisers and history
	logic                 line0_s1_ff;
	logic                 line0_s2_ff;
	logic                 line0_prev_ff;
	logic [PORT_PINS-1:0] port_s1_ff;
	logic [PORT_PINS-1:0] port_s2_ff;
	logic [PORT_PINS-1:0] port_latch_ff;
	logic                 port_init_ff;

	// core handshake outputs
	logic                 take_ff;
	logic [VEC_W-1:0]     vec_ff;

	// address decode
	wire sel_ctrl   = (reg_addr == OFS_IRQ_CTRL);
	wire sel_rst    = (reg_addr == OFS_RST_CTRL);
	wire sel_flags  = (reg_addr == OFS_FLAGS);
	wire sel_enable = (reg_addr == OFS_ENABLE);
	wire sel_prio   = (reg_addr == OFS_PRIO);
	wire sel_status = (reg_addr == OFS_STATUS);
	wire sel_port   = (reg_addr == OFS_PORT);
	wire sel_edge   = (reg_addr == OFS_EDGE);
	wire wr_ctrl    = reg_wr & sel_ctrl;
	wire wr_flags   = reg_wr & sel_flags;
	wire rd_port    = reg_rd & sel_port;

	// pin events: line zero edge after two-flop sync, port mismatch vs latch
	wire line0_rise = line0_s2_ff & ~line0_prev_ff;
	wire line0_fall = ~line0_s2_ff & line0_prev_ff;
	wire line0_evt  = edge_rise_ff ? line0_rise : line0_fall;
	wire port_mism  = port_init_ff & (port_s2_ff != port_latch_ff);

	// per-source set conditions, independent of any enable
	logic [NSRC-1:0] set_vec;
	always_comb begin
		set_vec            = periph_event;
		set_vec[SRC_LINE0] = line0_evt;
		set_vec[SRC_PORT]  = port_mism;
	end

	// event flags, one cell per source
	logic [NSRC-1:0] flags;
	for (genvar i = 0; i < NSRC; i++) begin : g_flag
		tlpi_flag_cell u_cell (
			.ref_clk (ref_clk),
			.rst_n   (rst_n),
			.set_evt (set_vec[i]),
			.wr_en   (wr_flags),
			.wr_val  (reg_wdata[i]),
			.flag    (flags[i])
		);
	end

	// line zero has no priority bit of its own: it is always high
	logic [NSRC-1:0] prio_eff;
	logic [NSRC-1:0] core_mask;
	always_comb begin
		prio_eff            = prio_ff;
		prio_eff[SRC_LINE0] = 1'b1;
		core_mask           = '0;
		for (int k = 0; k < int'(CORE_SRC_N); k++) begin
			core_mask[k] = 1'b1;
		end
	end

	// eligibility: flag and individual enable first
	wire [NSRC-1:0] active = flags & enable_ff;

	// compatibility mode: peripherals need peripheral_irq_enable, all need gie; priority ignored
	wire compat_req = global_irq_enable_ff
		& (|(active & (core_mask | {NSRC{peripheral_irq_enable_ff}})));

	// priority mode: bit 7 gates high sources, bit 6 gates low sources;
	// a low entry is held off while a high handler runs, else it would nest under it
	wire high_priority_global_enable = global_irq_enable_ff;
	wire low_priority_global_enable  = peripheral_irq_enable_ff;
	wire hi_req = high_priority_global_enable & (|(active & prio_eff));
	wire lo_req = low_priority_global_enable & (|(active & ~prio_eff))
		& (level_ff != LVL_HIGH) & (level_ff != LVL_LOW_HIGH);

	// accept only at a boundary, never in the cycle of a return
	wire at_edge = instr_boundary & ~return_from_handler_instr;
	wire take_hi = at_edge & (priority_feature_enable_ff ? hi_req : compat_req);
	wire take_lo = at_edge & priority_feature_enable_ff & lo_req & ~hi_req;
	wire take    = take_hi | take_lo;

	// return handling: which level is being left
	wire ret_high = return_from_handler_instr & ((level_ff == LVL_HIGH) || (level_ff == LVL_LOW_HIGH));
	wire ret_low  = return_from_handler_instr & (level_ff == LVL_LOW);

	// handler nesting; a high entry from the low level stacks on top of it
	always_comb begin
		nxt_level = level_ff;
		case (level_ff)
			LVL_IDLE: begin
				if (take_hi) begin
					nxt_level = LVL_HIGH;
				end else if (take_lo) begin
					nxt_level = LVL_LOW;
				end
			end
			LVL_LOW: begin
				if (ret_low) begin
					nxt_level = LVL_IDLE;
				end else if (take_hi) begin
					nxt_level = LVL_LOW_HIGH;
				end
			end
			LVL_HIGH: begin
				if (ret_high) begin
					nxt_level = LVL_IDLE;
				end
			end
			LVL_LOW_HIGH: begin
				if (ret_high) begin
					nxt_level = LVL_LOW;
				end
			end
			default: begin
				nxt_level = LVL_IDLE;
			end
		endcase
	end

	// global enables: software write, then hardware clear on entry, set on return
	always_comb begin
		nxt_gie  = global_irq_enable_ff;
		nxt_peripheral_irq_enable = peripheral_irq_enable_ff;
		if (wr_ctrl) begin
			nxt_gie  = reg_wdata[BIT_GIE];
			nxt_peripheral_irq_enable = reg_wdata[BIT_PERIPHERAL_IRQ_ENABLE];
		end
		if (take_hi) begin
			nxt_gie = 1'b0;
		end
		if (take_lo) begin
			nxt_peripheral_irq_enable = 1'b0;
		end
		if (ret_high) begin
			nxt_gie = 1'b1;
		end
		if (ret_low) begin
			nxt_peripheral_irq_enable = 1'b1;
		end
	end

	// vector choice; compatibility mode only ever takes the high path
	wire [VEC_W-1:0] vec_sel = take_lo ? VEC_LOW : VEC_HIGH;

	// flag, enable and priority register read views, upper bits zero
	logic [DATA_W-1:0] flags_rd;
	logic [DATA_W-1:0] enable_rd;
	logic [DATA_W-1:0] prio_rd;
	always_comb begin
		flags_rd             = '0;
		enable_rd            = '0;
		prio_rd              = '0;
		flags_rd[NSRC-1:0]   = flags;
		enable_rd[NSRC-1:0]  = enable_ff;
		prio_rd[NSRC-1:0]    = prio_eff;
	end

	// status and control views
	wire [DATA_W-1:0] ctrl_rd = {global_irq_enable_ff, peripheral_irq_enable_ff, {(DATA_W-2){1'b0}}};
	wire [DATA_W-1:0] rst_rd  = {priority_feature_enable_ff, {(DATA_W-1){1'b0}}};
	wire [DATA_W-1:0] stat_rd = {{(DATA_W-3){1'b0}}, priority_feature_enable_ff,
		(level_ff == LVL_LOW) || (level_ff == LVL_LOW_HIGH),
		(level_ff == LVL_HIGH) || (level_ff == LVL_LOW_HIGH)};
	wire [DATA_W-1:0] port_rd = {{(DATA_W-PORT_PINS){1'b0}}, port_s2_ff};
	wire [DATA_W-1:0] edge_rd = {{(DATA_W-1){1'b0}}, edge_rise_ff};

	// read multiplexer; unmapped offsets read zero
	wire [DATA_W-1:0] rd_mux =
		sel_ctrl   ? ctrl_rd   :
		sel_rst    ? rst_rd    :
		sel_flags  ? flags_rd  :
		sel_enable ? enable_rd :
		sel_prio   ? prio_rd   :
		sel_status ? stat_rd   :
		sel_port   ? port_rd   :
		sel_edge   ? edge_rd   : '0;

	// pin synchronisers; first stage is read only by the second
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			line0_s1_ff   <= 1'b0;
			line0_s2_ff   <= 1'b0;
			line0_prev_ff <= 1'b0;
			port_s1_ff    <= '0;
			port_s2_ff    <= '0;
		end else begin
			line0_s1_ff   <= line_zero_pin;
			line0_s2_ff   <= line0_s1_ff;
			line0_prev_ff <= line0_s2_ff;
			port_s1_ff    <= upper_port_change_pins;
			port_s2_ff    <= port_s1_ff;
		end
	end

	// port latch: caught once after reset, then on each port read,
	// which is how software ends a mismatch before clearing the flag
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			port_latch_ff <= '0;
			port_init_ff  <= 1'b0;
		end else begin
			port_init_ff <= 1'b1;
			if (!port_init_ff || rd_port) begin
				port_latch_ff <= port_s2_ff;
			end
		end
	end

	// software registers
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			priority_feature_enable_ff <= 1'b0;
			enable_ff                  <= RST_ENABLE[NSRC-1:0];
			prio_ff                    <= RST_PRIO[NSRC-1:0];
			edge_rise_ff               <= RST_EDGE;
		end else if (reg_wr) begin
			if (sel_rst) begin
				priority_feature_enable_ff <= reg_wdata[BIT_PRIO_EN];
			end else if (sel_enable) begin
				enable_ff <= reg_wdata[NSRC-1:0];
			end else if (sel_prio) begin
				prio_ff <= reg_wdata[NSRC-1:0];
			end else if (sel_edge) begin
				edge_rise_ff <= reg_wdata[BIT_EDGE_L0];
			end
		end
	end

	// global enables and handler level
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			global_irq_enable_ff     <= 1'b0;
			peripheral_irq_enable_ff <= 1'b0;
			level_ff                 <= LVL_IDLE;
		end else begin
			global_irq_enable_ff     <= nxt_gie;
			peripheral_irq_enable_ff <= nxt_peripheral_irq_enable;
			level_ff                 <= nxt_level;
		end
	end

	// core handshake: one-cycle take with vector held until the next take
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			take_ff <= 1'b0;
			vec_ff  <= VEC_HIGH;
		end else begin
			take_ff <= take;
			if (take) begin
				vec_ff <= vec_sel;
			end
		end
	end

	// register read data, valid the cycle after the strobe only
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata_ff <= '0;
		end else begin
			rdata_ff <= reg_rd ? rd_mux : '0;
		end
	end

	// handler level outputs
	logic act_hi_ff;
	logic act_lo_ff;
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			act_hi_ff <= 1'b0;
			act_lo_ff <= 1'b0;
		end else begin
			act_hi_ff <= (nxt_level == LVL_HIGH) || (nxt_level == LVL_LOW_HIGH);
			act_lo_ff <= (nxt_level == LVL_LOW) || (nxt_level == LVL_LOW_HIGH);
		end
	end

	// outputs
	assign reg_rdata         = rdata_ff;
	assign vector_take       = take_ff;
	assign push_return       = take_ff;
	assign vector_addr       = vec_ff;
	assign handler_active_hi = act_hi_ff;
	assign handler_active_lo = act_lo_ff;

endmodule : tlpi_ctrl

// ===== logic/tlpi_flag_cell.sv
// tlpi_flag_cell: one sticky event flag, hardware set, software write
// assumes: set and write arrive on ref_clk; a set beats a clear in the same cycle
`timescale 1ns/1ps
module tlpi_flag_cell (
	input  wire logic ref_clk,
	input  wire logic rst_n,
	input  wire logic set_evt,
	input  wire logic wr_en,
	input  wire logic wr_val,
	output logic      flag
);
	logic flag_ff;
	logic nxt_flag;

	// event wins over a software clear so no event is lost
	assign nxt_flag = set_evt ? 1'b1 : (wr_en ? wr_val : flag_ff);

	// flag store
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			flag_ff <= 1'b0;
		end else begin
			flag_ff <= nxt_flag;
		end
	end

	assign flag = flag_ff;

endmodule : tlpi_flag_cell

// ===== logic/tlpi_pkg.sv
// tlpi_pkg: constants for the two-level priority interrupt controller
// assumes: 8-bit register port, 21-bit program counter in the core
package tlpi_pkg;

	// register port geometry
	localparam int unsigned DATA_W = 8;
	localparam int unsigned ADDR_W = 5;

	// register offsets
	localparam logic [ADDR_W-1:0] OFS_IRQ_CTRL = 5'h00;
	localparam logic [ADDR_W-1:0] OFS_RST_CTRL = 5'h04;
	localparam logic [ADDR_W-1:0] OFS_FLAGS    = 5'h08;
	localparam logic [ADDR_W-1:0] OFS_ENABLE   = 5'h0C;
	localparam logic [ADDR_W-1:0] OFS_PRIO     = 5'h10;
	localparam logic [ADDR_W-1:0] OFS_STATUS   = 5'h14;
	localparam logic [ADDR_W-1:0] OFS_PORT     = 5'h18;
	localparam logic [ADDR_W-1:0] OFS_EDGE     = 5'h1C;

	// field positions
	localparam int unsigned BIT_GIE      = 7;
	localparam int unsigned BIT_PERIPHERAL_IRQ_ENABLE     = 6;
	localparam int unsigned BIT_PRIO_EN  = 7;
	localparam int unsigned BIT_EDGE_L0  = 0;
	localparam int unsigned BIT_ST_HIGH  = 0;
	localparam int unsigned BIT_ST_LOW   = 1;
	localparam int unsigned BIT_ST_MODE  = 2;

	// reset values
	localparam logic [DATA_W-1:0] RST_ENABLE = 8'h00;
	localparam logic [DATA_W-1:0] RST_PRIO   = 8'hFF;
	localparam logic              RST_EDGE   = 1'h1;

	// vector addresses
	localparam int unsigned       VEC_W    = 21;
	localparam logic [VEC_W-1:0]  VEC_HIGH = 21'h000008;
	localparam logic [VEC_W-1:0]  VEC_LOW  = 21'h000018;

	// source numbering: sources below CORE_SRC_N are core, the rest peripheral
	localparam int unsigned SRC_LINE0  = 0;
	localparam int unsigned SRC_PORT   = 1;
	localparam int unsigned CORE_SRC_N = 3;
	localparam int unsigned PORT_PINS  = 4;

	// handler nesting level
	typedef enum logic [1:0] {
		LVL_IDLE,
		LVL_LOW,
		LVL_HIGH,
		LVL_LOW_HIGH
	} tlpi_level_e;

endpackage : tlpi_pkg

// ===== test/tb_tlpi_ctrl.sv
// tb_tlpi_ctrl: self-checking bench for the interrupt controller
// assumes: core model makes boundaries; registers reached over the plain port
`timescale 1ns/1ps
module tb_tlpi_ctrl
	import tlpi_pkg::*;
;
	logic                 ref_clk, rst_n, reg_wr, reg_rd, line_zero_pin, vector_take, push_return, ret_req;
	logic                 instr_boundary, return_from_handler_instr, handler_active_hi, handler_active_lo;
	logic [ADDR_W-1:0]    reg_addr;
	logic [DATA_W-1:0]    reg_wdata, reg_rdata, periph_event;
	logic [PORT_PINS-1:0] upper_port_change_pins;
	logic [VEC_W-1:0]     vector_addr;
	logic [VEC_W-1:0]     tq[$];
	int                   n_errors, cmp_count, depth, seed, i;
	logic [ADDR_W-1:0]    ra[7] = '{OFS_IRQ_CTRL, OFS_RST_CTRL, OFS_ENABLE, OFS_PRIO, OFS_STATUS, OFS_EDGE, 5'h02};
	logic [7:0]           rv[7] = '{8'h00, 8'h00, 8'h00, 8'hFF, 8'h00, 8'h01, 8'h00};

	initial begin
		ref_clk = 1'b0;
		forever #10 ref_clk = ~ref_clk;
	end

	tlpi_ctrl #(.NSRC(8)) tlpi_ctrl_i (.ref_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
		.line_zero_pin, .upper_port_change_pins, .periph_event, .instr_boundary, .return_from_handler_instr,
		.vector_take, .push_return, .vector_addr, .handler_active_hi, .handler_active_lo);
	tlpi_core_model tlpi_core_model_i (.ref_clk, .rst_n, .push_return, .ret_req, .instr_boundary,
		.return_from_handler_instr, .depth);

	// every take is queued so none is lost while a register task runs
	always @(posedge ref_clk) begin
		if (vector_take === 1'b1)
			tq.push_back(vector_addr);
	end

	function automatic logic [VEC_W-1:0] xvec(input int mode, input int pr);
		return (mode != 0 && pr == 0) ? VEC_LOW : VEC_HIGH;
	endfunction : xvec

	task automatic chk8(input string n, input logic [7:0] e, input logic [7:0] g);
		cmp_count++;
		if (g !== e) begin
			n_errors++;
			$display("MISMATCH %s expected %h seen %h", n, e, g);
		end
	endtask : chk8

	task automatic chkv(input logic [VEC_W-1:0] e, input logic [VEC_W-1:0] g);
		cmp_count++;
		if (g !== e) begin
			n_errors++;
			$display("MISMATCH vector expected %h seen %h", e, g);
		end
	endtask : chkv

	task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] v);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask : wr

	task automatic rd(input logic [ADDR_W-1:0] a, input logic [7:0] e);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		@(negedge ref_clk);
		chk8($sformatf("reg_%h", a), e, reg_rdata);
	endtask : rd

	task automatic ev(input logic [7:0] m);
		@(posedge ref_clk);
		periph_event <= m;
		@(posedge ref_clk);
		periph_event <= 8'h00;
	endtask : ev

	// quiet window of three instruction cycles: no take may appear
	task automatic none;
		repeat (12) @(posedge ref_clk);
		chk8("takes", 8'h00, 8'(tq.size()));
	endtask : none

	task automatic take(input logic [VEC_W-1:0] e);
		for (i = 0; i < 40 && tq.size() == 0; i++)
			@(posedge ref_clk);
		if (tq.size() == 0)
			chkv(e, 21'h1FFFFF);
		else
			chkv(e, tq.pop_front());
	endtask : take

	task automatic ret;
		@(posedge ref_clk);
		ret_req <= 1'b1;
		@(posedge ref_clk);
		ret_req <= 1'b0;
		repeat (8) @(posedge ref_clk);
	endtask : ret

	task automatic tally_and_finish;
		$display("comparisons %0d mismatches %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : tally_and_finish

	initial begin
		repeat (5000) @(posedge ref_clk);
		n_errors++;
		tally_and_finish();
	end

	initial begin
		{rst_n, reg_addr, reg_wdata, reg_wr, reg_rd, line_zero_pin, periph_event, ret_req} = '0;
		upper_port_change_pins = 4'h0;
		seed = 86943;
		repeat (20) @(posedge ref_clk);
		rst_n <= 1'b1;
		for (int k = 0; k < 7; k++)
			rd(ra[k], rv[k]);
		// compatibility: low priority bit must not matter, peripherals need bit 6
		wr(OFS_PRIO, 8'hF7);
		wr(OFS_ENABLE, 8'h0C);
		wr(OFS_IRQ_CTRL, 8'h80);
		ev(8'h08);
		none();
		rd(OFS_FLAGS, 8'h08);
		wr(OFS_IRQ_CTRL, 8'hC0);
		take(xvec(0, 0));
		rd(OFS_IRQ_CTRL, 8'h40);
		chk8("depth", 8'h01, 8'(depth));
		wr(OFS_FLAGS, 8'h00);
		ret();
		rd(OFS_IRQ_CTRL, 8'hC0);
		wr(OFS_ENABLE, 8'h18);
		ev(8'h04);
		none();
		rd(OFS_FLAGS, 8'h04);
		wr(OFS_FLAGS, 8'h00);
		// priority mode: low handler then a high one on top of it
		wr(OFS_RST_CTRL, 8'h80);
		ev(8'h08);
		take(xvec(1, 0));
		rd(OFS_IRQ_CTRL, 8'h80);
		ev(8'h10);
		take(xvec(1, 1));
		rd(OFS_IRQ_CTRL, 8'h00);
		rd(OFS_STATUS, 8'h07);
		wr(OFS_FLAGS, 8'h00);
		ret();
		rd(OFS_IRQ_CTRL, 8'h80);
		ret();
		rd(OFS_IRQ_CTRL, 8'hC0);
		// both levels pending at once
		wr(OFS_IRQ_CTRL, 8'h00);
		ev(8'h18);
		wr(OFS_IRQ_CTRL, 8'hC0);
		take(xvec(1, 1));
		wr(OFS_FLAGS, 8'h08);
		ret();
		take(xvec(1, 0));
		wr(OFS_FLAGS, 8'h00);
		ret();
		chk8("depth", 8'h00, 8'(depth));
		// port change: flag keeps coming back until the port is read
		wr(OFS_ENABLE, 8'h00);
		rd(OFS_PORT, 8'h00);
		upper_port_change_pins <= 4'($random(seed)) | 4'h1;
		repeat (10) @(posedge ref_clk);
		wr(OFS_FLAGS, 8'h00);
		rd(OFS_FLAGS, 8'h02);
		rd(OFS_PORT, {4'h0, upper_port_change_pins});
		wr(OFS_FLAGS, 8'h00);
		rd(OFS_FLAGS, 8'h00);
		// line zero latency, at most four instruction cycles
		wr(OFS_ENABLE, 8'h01);
		@(posedge ref_clk);
		line_zero_pin <= 1'b1;
		for (i = 0; i < 16 && tq.size() == 0; i++)
			@(posedge ref_clk);
		chk8("latency", 8'h01, 8'(i < 16));
		take(VEC_HIGH);
		wr(OFS_FLAGS, 8'h00);
		ret();
		// falling edge select on line zero: flag sets, nothing enabled so no take
		wr(OFS_ENABLE, 8'h00);
		wr(OFS_EDGE, 8'h00);
		line_zero_pin <= 1'b0;
		repeat (6) @(posedge ref_clk);
		rd(OFS_FLAGS, 8'h01);
		chk8("takes", 8'h00, 8'(tq.size()));
		tally_and_finish();
	end
endmodule : tb_tlpi_ctrl

// ===== test/tlpi_core_model.sv
// tlpi_core_model: core side, boundary every four clocks, returns on request
// assumes: ret_req is a one-cycle pulse from the bench
`timescale 1ns/1ps
module tlpi_core_model (
	input  wire logic ref_clk,
	input  wire logic rst_n,
	input  wire logic push_return,
	input  wire logic ret_req,
	output logic      instr_boundary,
	output logic      return_from_handler_instr,
	output int        depth
);
	logic [1:0] cnt_ff;
	logic       pend_ff;
	// return lands mid-instruction so it never shares an edge with a boundary
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_ff <= 2'h0;
			pend_ff <= 1'b0;
			depth <= 0;
			instr_boundary <= 1'b0;
			return_from_handler_instr <= 1'b0;
		end else begin
			cnt_ff <= cnt_ff + 2'h1;
			instr_boundary <= (cnt_ff == 2'h2);
			return_from_handler_instr <= pend_ff && cnt_ff == 2'h0;
			pend_ff <= ret_req | (pend_ff && cnt_ff != 2'h0);
			depth <= depth + int'(push_return) - int'(return_from_handler_instr);
		end
	end
endmodule : tlpi_core_model

// ===== test/tlpi_ctrl_assertions.sv
// tlpi_ctrl_chk: port-level properties of the interrupt controller
// assumes: bound to tlpi_ctrl; one clock, async active-low reset
`timescale 1ns/1ps
module tlpi_ctrl_chk
	import tlpi_pkg::*;
(
	input wire logic              ref_clk,
	input wire logic              rst_n,
	input wire logic [ADDR_W-1:0] reg_addr,
	input wire logic [DATA_W-1:0] reg_wdata,
	input wire logic              reg_wr,
	input wire logic              instr_boundary,
	input wire logic              return_from_handler_instr,
	input wire logic              vector_take,
	input wire logic              push_return,
	input wire logic [VEC_W-1:0]  vector_addr,
	input wire logic              handler_active_hi,
	input wire logic              handler_active_lo
);
	// shadow of the mode bit; a take on the very edge of a mode write is not covered
	logic mode_ff;
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n)
			mode_ff <= 1'b0;
		else if (reg_wr && reg_addr == OFS_RST_CTRL)
			mode_ff <= reg_wdata[BIT_PRIO_EN];
	end

	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);

	property p_take_push; vector_take |-> push_return; endproperty
	a_take_push: assert property (p_take_push) else $error("take without push");
	property p_vec_legal; vector_take |-> (vector_addr == VEC_HIGH || vector_addr == VEC_LOW); endproperty
	a_vec_legal: assert property (p_vec_legal) else $error("illegal vector");
	property p_at_bound; vector_take |-> $past(instr_boundary) && !$past(return_from_handler_instr); endproperty
	a_at_bound: assert property (p_at_bound) else $error("take off boundary");
	property p_hi_run; vector_take && vector_addr == VEC_HIGH |-> handler_active_hi; endproperty
	a_hi_run: assert property (p_hi_run) else $error("high handler not active");
	property p_lo_run; vector_take && vector_addr == VEC_LOW |-> handler_active_lo && !handler_active_hi; endproperty
	a_lo_run: assert property (p_lo_run) else $error("low handler state wrong");
	property p_compat; vector_take && !mode_ff |-> vector_addr == VEC_HIGH; endproperty
	a_compat: assert property (p_compat) else $error("compat vector not high");
	property p_ret_quiet; return_from_handler_instr |=> !vector_take; endproperty
	a_ret_quiet: assert property (p_ret_quiet) else $error("take after return");
	property p_hi_fall; $fell(handler_active_hi) |-> $past(return_from_handler_instr); endproperty
	a_hi_fall: assert property (p_hi_fall) else $error("high handler left early");
	property p_nest; $past(handler_active_lo) && vector_take |-> vector_addr == VEC_HIGH; endproperty
	a_nest: assert property (p_nest) else $error("low took over low");

	c_low: cover property (vector_take && vector_addr == VEC_LOW);
	c_pre: cover property (handler_active_lo && vector_take && vector_addr == VEC_HIGH);
	c_ret: cover property (return_from_handler_instr);
endmodule : tlpi_ctrl_chk

bind tlpi_ctrl tlpi_ctrl_chk tlpi_ctrl_chk_i (.ref_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .instr_boundary,
	.return_from_handler_instr, .vector_take, .push_return, .vector_addr, .handler_active_hi, .handler_active_lo);
